//--- dv/rfc_host_model.sv
// Host controller model driving the register port
module rfc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic      [6:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // Released data must not keep showing the last value
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
  // Rates below 30 kbps select the prescaled rate word, carry out of bit 21 instead of bit 16
  function automatic logic pick_prescale(input int bps);
    return (bps < 30_000);
  endfunction
endmodule

//--- dv/rfc_properties.sv
// Concurrent checks on the frequency control block ports
module rfc_properties
  import rfc_pkg::*;
#(
  parameter int TUNE_CNT = TUNE_CYCLES
) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              reg_wr_i,
  input wire logic        [6:0] reg_addr_i,
  input wire logic        [7:0] reg_wdata_i,
  input wire logic              tx_on_i,
  input wire logic              rx_on_i,
  input wire logic              fifo_mode_i,
  input wire logic              tx_packet_active_i,
  input wire logic              afc_enable_i,
  input wire logic        [2:0] afc_cycle_length_i,
  input wire logic        [7:0] pull_in_limit_i,
  input wire logic              preamble_detect_i,
  input wire logic              packet_end_i,
  input wire logic              multi_packet_i,
  input wire rfc_state_type     state_o,
  input wire logic signed [7:0] afc_correction_value_o,
  input wire logic       [10:0] deviation_o,
  input wire logic              tx_bit_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Helpers
  // ----------
  logic              hop_wr;
  logic       [15:0] tune_len_q;
  logic        [7:0] dev_wd_q;
  logic signed [9:0] lim;
  assign hop_wr = reg_wr_i && (reg_addr_i == ADDR_HOP_CHAN || reg_addr_i == ADDR_HOP_STEP);
  // Clamp is the pull-in limit times 4, cut to the 8-bit range of the correction
  assign lim = (pull_in_limit_i > 8'h1f) ? 10'sh07f : $signed({pull_in_limit_i, 2'b00});
  always_ff @(posedge clk_i) begin
    if (!rstn_i || state_o != ST_TUNE) begin
      tune_len_q <= 16'h0000;
    end else begin
      tune_len_q <= tune_len_q + 16'h0001;
    end
    if (!rstn_i) begin
      dev_wd_q <= RST_DEV_LOW;
    end else if (reg_wr_i && reg_addr_i == ADDR_DEV_LOW) begin
      dev_wd_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------
  // Assertions
  // ----------
  property p_tune_len;
    state_o == ST_TUNE |-> int'(tune_len_q) < TUNE_CNT;
  endproperty
  a_tune_len: assert property (p_tune_len) else $error("tune state too long");
  property p_retune;
    hop_wr && ((state_o == ST_TX && tx_on_i && !(fifo_mode_i && tx_packet_active_i)) ||
      (state_o == ST_RX && rx_on_i)) |=> state_o == ST_TUNE;
  endproperty
  a_retune: assert property (p_retune) else $error("hop write did not retune");
  property p_defer;
    hop_wr && state_o == ST_TX && tx_on_i && fifo_mode_i && tx_packet_active_i |=> state_o == ST_TX;
  endproperty
  a_defer: assert property (p_defer) else $error("retune during packet");
  property p_dev;
    reg_wr_i && reg_addr_i == ADDR_DEV_LOW |->
      ##[1:2] deviation_o[9:2] == dev_wd_q && deviation_o[1:0] == 2'b00;
  endproperty
  a_dev: assert property (p_dev) else $error("deviation word wrong");
  property p_tx_corr;
    (state_o == ST_TX)[*2] |-> afc_correction_value_o == 8'sh00;
  endproperty
  a_tx_corr: assert property (p_tx_corr) else $error("correction active in transmit");
  property p_len0;
    state_o == ST_RX && rx_on_i && !hop_wr && afc_cycle_length_i == 3'h0 && !packet_end_i |=>
      $stable(afc_correction_value_o) || afc_correction_value_o == 8'sh00;
  endproperty
  a_len0: assert property (p_len0) else $error("correction with zero cycle");
  property p_freeze;
    afc_enable_i && preamble_detect_i && state_o == ST_RX && rx_on_i && !hop_wr &&
      !packet_end_i ##1 rx_on_i && afc_enable_i && !hop_wr && !packet_end_i |=>
      $stable(afc_correction_value_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("correction moved after preamble");
  property p_mpk;
    packet_end_i && multi_packet_i && state_o == ST_RX |=> afc_correction_value_o == 8'sh00;
  endproperty
  a_mpk: assert property (p_mpk) else $error("correction kept over packet end");
  property p_clamp;
    state_o == ST_RX && $changed(afc_correction_value_o) && $stable(pull_in_limit_i) |->
      afc_correction_value_o <= lim && afc_correction_value_o >= -lim;
  endproperty
  a_clamp: assert property (p_clamp) else $error("correction beyond pull-in range");
  property p_no_tick;
    (state_o != ST_TX)[*2] |-> !tx_bit_tick_o;
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("bit tick outside transmit");
  c_retune: cover property (state_o == ST_TUNE ##1 state_o == ST_TX);
  c_clamp: cover property (state_o == ST_RX && afc_correction_value_o == lim);
  c_tick: cover property (tx_bit_tick_o);
endmodule

bind rfc_top rfc_properties #(.TUNE_CNT(TUNE_CNT)) u_props (
  .clk_i, .rstn_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .tx_on_i, .rx_on_i, .fifo_mode_i,
  .tx_packet_active_i, .afc_enable_i, .afc_cycle_length_i, .pull_in_limit_i,
  .preamble_detect_i, .packet_end_i, .multi_packet_i, .state_o, .afc_correction_value_o,
  .deviation_o, .tx_bit_tick_o
);

//--- dv/tb_rfc_top.sv
// Self-checking testbench for the frequency control block
module tb_rfc_top
  import rfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Signals and helpers
  // ----------
  localparam int TC = 8;
  localparam logic [6:0] RA [8] = '{7'h6e, 7'h6f, 7'h71, 7'h72, 7'h73, 7'h74, 7'h79, 7'h7a};
  localparam logic [7:0] RV [8] = '{8'h0a, 8'h3d, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  logic               clk_i, rstn_i, reg_wr_i, tx_on_i, rx_on_i, fifo_mode_i;
  logic               tx_packet_active_i, band_half_select_i, tx_rate_prescale_i;
  logic               afc_enable_i, rx_bit_tick_i, preamble_detect_i, packet_end_i;
  logic               multi_packet_i, tx_bit_tick_o;
  logic         [2:0] afc_gain_shift_i, afc_cycle_length_i;
  logic         [6:0] reg_addr_i;
  logic         [7:0] reg_wdata_i, reg_rdata_o, pull_in_limit_i, rd_v;
  logic signed  [7:0] afc_error_i, afc_correction_value_o;
  logic signed [23:0] freq_delta_o;
  logic        [10:0] deviation_o;
  rfc_state_type      state_o;
  int                 num_errors = 0;
  int                 check_count = 0;

  rfc_top #(.TUNE_CNT(TC)) dut (
    .clk_i, .rstn_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .tx_on_i, .rx_on_i,
    .fifo_mode_i, .tx_packet_active_i, .band_half_select_i, .tx_rate_prescale_i,
    .afc_enable_i, .afc_gain_shift_i, .afc_cycle_length_i, .pull_in_limit_i, .afc_error_i,
    .rx_bit_tick_i, .preamble_detect_i, .packet_end_i, .multi_packet_i, .state_o,
    .freq_delta_o, .deviation_o, .afc_correction_value_o, .tx_bit_tick_o
  );
  rfc_host_model host (
    .clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_st(input rfc_state_type s);
    int n;
    n = 0;
    while (state_o !== s && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk(state_o, s);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      rx_bit_tick_i <= 1'b1;
      @(posedge clk_i);
      rx_bit_tick_i <= 1'b0;
    end
    cyc(2);
    @(negedge clk_i);
  endtask
  // Hop of 10 kHz units seen in 156.25 Hz steps, plus a correction in steps
  function automatic logic [23:0] hop(input int s, input int c, input int corr);
    return 24'(s * c * 64 + corr);
  endfunction
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    foreach (RA[i]) begin
      host.rd(RA[i], rd_v);
      chk(rd_v, RV[i]);
    end
    host.wr(ADDR_AFC_CORR, 8'h55);
    host.rd(ADDR_AFC_CORR, rd_v);
    chk(rd_v, 8'h00);
    host.wr(ADDR_OFS_HIGH, 8'hff);
    host.rd(ADDR_OFS_HIGH, rd_v);
    chk(rd_v, 8'h03);
    host.wr(7'h10, 8'h5a);
    host.rd(7'h10, rd_v);
    chk(rd_v, 8'h00);
    host.wr(ADDR_OFS_HIGH, 8'h00);
  endtask
  task automatic t_dev();
    host.wr(ADDR_MOD_CTL2, 8'h04);
    host.wr(ADDR_DEV_LOW, 8'h10);
    cyc(2);
    @(negedge clk_i);
    chk(deviation_o, 11'h440);
    @(posedge clk_i);
    band_half_select_i <= 1'b1;
    cyc(2);
    @(negedge clk_i);
    chk(deviation_o, 11'h440);
  endtask
  task automatic t_hop_tx();
    int n;
    host.wr(ADDR_HOP_STEP, 8'd100);
    host.wr(ADDR_HOP_CHAN, 8'd5);
    cyc(2);
    @(negedge clk_i);
    chk(freq_delta_o, hop(100, 5, 0));
    @(posedge clk_i);
    tx_on_i <= 1'b1;
    afc_enable_i <= 1'b1;
    host.wr(ADDR_OFS_LOW, 8'hfb);
    host.wr(ADDR_OFS_HIGH, 8'h03);
    wait_st(ST_TX);
    cyc(2);
    @(negedge clk_i);
    chk(freq_delta_o, hop(100, 5, -10));
    host.wr(ADDR_HOP_CHAN, 8'd6);
    n = 0;
    @(negedge clk_i);
    while (state_o === ST_TUNE && n < 100) begin
      n++;
      @(negedge clk_i);
    end
    chk(24'(n), 24'(TC));
    chk(state_o, ST_TX);
    cyc(1);
    @(negedge clk_i);
    chk(freq_delta_o, hop(100, 6, -10));
    @(posedge clk_i);
    fifo_mode_i <= 1'b1;
    tx_packet_active_i <= 1'b1;
    host.wr(ADDR_HOP_CHAN, 8'd7);
    cyc(5);
    @(negedge clk_i);
    chk(state_o, ST_TX);
    chk(freq_delta_o, hop(100, 6, -10));
    @(posedge clk_i);
    tx_packet_active_i <= 1'b0;
    wait_st(ST_TUNE);
    wait_st(ST_TX);
    cyc(2);
    @(negedge clk_i);
    chk(freq_delta_o, hop(100, 7, -10));
    @(posedge clk_i);
    fifo_mode_i <= 1'b0;
    tx_on_i <= 1'b0;
    wait_st(ST_IDLE);
  endtask
  task automatic t_rate(input logic [7:0] hi, input int bps, input int span, input int exp);
    int n;
    host.wr(ADDR_TXDR_HIGH, hi);
    host.wr(ADDR_TXDR_LOW, 8'h00);
    @(posedge clk_i);
    tx_rate_prescale_i <= host.pick_prescale(bps);
    tx_on_i <= 1'b1;
    wait_st(ST_TX);
    n = 0;
    repeat (span) begin
      @(negedge clk_i);
      n += int'(tx_bit_tick_o === 1'b1);
    end
    chk(24'(n >= exp - 1 && n <= exp + 1), 24'h1);
    @(posedge clk_i);
    tx_on_i <= 1'b0;
    wait_st(ST_IDLE);
  endtask
  task automatic t_afc();
    @(posedge clk_i);
    rx_on_i <= 1'b1;
    afc_enable_i <= 1'b0;
    wait_st(ST_RX);
    cyc(2);
    @(negedge clk_i);
    chk(freq_delta_o, hop(100, 7, -10 - 6000));
    @(posedge clk_i);
    afc_enable_i <= 1'b1;
    multi_packet_i <= 1'b1;
    pull_in_limit_i <= 8'h02;
    afc_error_i <= 8'sd3;
    ticks(4);
    chk(afc_correction_value_o, 8'sd3);
    ticks(4);
    chk(afc_correction_value_o, 8'sd6);
    ticks(4);
    chk(afc_correction_value_o, 8'sd8);
    chk(freq_delta_o, hop(100, 7, 16 - 6000));
    host.rd(ADDR_AFC_CORR, rd_v);
    chk(rd_v, 8'h08);
    @(posedge clk_i);
    preamble_detect_i <= 1'b1;
    afc_error_i <= -8'sd3;
    @(posedge clk_i);
    preamble_detect_i <= 1'b0;
    ticks(8);
    chk(afc_correction_value_o, 8'sd8);
    @(posedge clk_i);
    packet_end_i <= 1'b1;
    @(posedge clk_i);
    packet_end_i <= 1'b0;
    @(negedge clk_i);
    chk(afc_correction_value_o, 8'sd0);
    @(posedge clk_i);
    afc_gain_shift_i <= 3'h1;
    afc_error_i <= 8'sd4;
    pull_in_limit_i <= 8'h40;
    ticks(4);
    chk(afc_correction_value_o, 8'sd2);
    @(posedge clk_i);
    afc_gain_shift_i <= 3'h0;
    afc_error_i <= -8'sd8;
    ticks(4);
    chk(afc_correction_value_o, -8'sd6);
    @(posedge clk_i);
    pull_in_limit_i <= 8'h01;
    ticks(4);
    chk(afc_correction_value_o, -8'sd4);
    @(posedge clk_i);
    packet_end_i <= 1'b1;
    afc_cycle_length_i <= 3'h0;
    @(posedge clk_i);
    packet_end_i <= 1'b0;
    ticks(8);
    chk(afc_correction_value_o, 8'sd0);
    @(posedge clk_i);
    rx_on_i <= 1'b0;
    wait_st(ST_IDLE);
  endtask
  // ----------
  // Main sequence and watchdog
  // ----------
  initial begin
    {tx_on_i, rx_on_i, fifo_mode_i, tx_packet_active_i, band_half_select_i} = '0;
    {tx_rate_prescale_i, afc_enable_i, rx_bit_tick_i, preamble_detect_i} = '0;
    {packet_end_i, multi_packet_i, afc_gain_shift_i, afc_error_i} = '0;
    afc_cycle_length_i = 3'h1;
    pull_in_limit_i = 8'h40;
    rstn_i = 1'b0;
    cyc(10);
    rstn_i <= 1'b1;
    t_regs();
    t_dev();
    t_hop_tx();
    t_rate(8'h10, 62_500, 8000, 10);
    t_rate(8'h80, 15_625, 9600, 3);
    t_afc();
    final_report();
  end
  initial begin
    #(40_000 * 20);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule

//--- rtl/rfc_pkg.sv
// Constants, state types and register map of the radio frequency control block
//
// Behaviour
// - Receive lowers synthesizer by fixed IF shift
// - Carrier is nominal plus step times channel
// - Hop write in TX/RX retunes, then resumes
// - TX FIFO packet finishes before hop applies
// - Deviation is word times 625 Hz
// - Deviation word top bit from modulation control
// - Offset word signed, scaled by band half
// - Offset and AFC share one correction register
// - AFC frozen after preamble until packet end
// - Multi-packet receive resets AFC each packet
// - AFC correction clamped to pull-in limit
// - Gain shift halves feedback per step
// - Measure two bits, correct, then settle
// - Cycle length one gives four bit times
// - Cycle length zero gives no correction
// - AFC correction readable, not scaled by band half
// - Bit rate is word times 1 MHz scaled
// - Rate word affects transmit timing only
// - Band half select one means upper band
package rfc_pkg;

  // ----------
  // Register map
  // ----------
  localparam logic [6:0] ADDR_AFC_CORR   = 7'h2b;
  localparam logic [6:0] ADDR_TXDR_HIGH  = 7'h6e;
  localparam logic [6:0] ADDR_TXDR_LOW   = 7'h6f;
  localparam logic [6:0] ADDR_MOD_CTL2   = 7'h71;
  localparam logic [6:0] ADDR_DEV_LOW    = 7'h72;
  localparam logic [6:0] ADDR_OFS_LOW    = 7'h73;
  localparam logic [6:0] ADDR_OFS_HIGH   = 7'h74;
  localparam logic [6:0] ADDR_HOP_CHAN   = 7'h79;
  localparam logic [6:0] ADDR_HOP_STEP   = 7'h7a;

  localparam logic [7:0] RST_TXDR_HIGH   = 8'h0a;
  localparam logic [7:0] RST_TXDR_LOW    = 8'h3d;
  localparam logic [7:0] RST_MOD_CTL2    = 8'h00;
  localparam logic [7:0] RST_DEV_LOW     = 8'h20;
  localparam logic [7:0] RST_OFS_LOW     = 8'h00;
  localparam logic [1:0] RST_OFS_HIGH    = 2'h0;
  localparam logic [7:0] RST_HOP_CHAN    = 8'h00;
  localparam logic [7:0] RST_HOP_STEP    = 8'h00;

  // Deviation top bit position inside modulation control two
  localparam int         DEV_TOP_BIT     = 2;

  // ----------
  // Frequency units (centihertz); output word counts 156.25 Hz steps
  // ----------
  localparam int         LSB_CHZ         = 15_625;
  localparam int         IF_SHIFT_CHZ    = 93_750_000;
  localparam int         HOP_UNIT_CHZ    = 1_000_000;
  localparam int         DEV_UNIT_CHZ    = 62_500;
  localparam int         LIMIT_UNIT_CHZ  = 62_500;
  localparam int         IF_SHIFT_CNT    = IF_SHIFT_CHZ / LSB_CHZ;
  localparam int         HOP_UNIT_SHIFT  = $clog2(HOP_UNIT_CHZ / LSB_CHZ);
  localparam int         DEV_UNIT_SHIFT  = $clog2(DEV_UNIT_CHZ / LSB_CHZ);
  localparam int         LIMIT_SHIFT     = $clog2(LIMIT_UNIT_CHZ / LSB_CHZ);
  localparam int         FREQ_W          = 24;
  localparam logic signed [FREQ_W-1:0] IF_SHIFT_WORD = FREQ_W'(IF_SHIFT_CNT);
  localparam logic signed [7:0] AFC_MAX  = 8'sh7f;

  // ----------
  // Timing
  // ----------
  localparam int         CLK_PERIOD_NS   = 20;
  localparam int         CLK_HZ          = 50_000_000;
  localparam int         RATE_REF_HZ     = 1_000_000;
  localparam int         RATE_DIV        = CLK_HZ / RATE_REF_HZ;
  localparam int         RATE_DIV_W      = 6;
  localparam int         RATE_SHIFT_BASE = 16;
  localparam int         RATE_SHIFT_STEP = 5;
  localparam int         RATE_ACC_W      = RATE_SHIFT_BASE + RATE_SHIFT_STEP;
  localparam int         TUNE_TIME_NS    = 200_000;
  localparam int         TUNE_CYCLES     = (TUNE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         TUNE_CNT_W      = 16;
  localparam logic [4:0] AFC_MEAS_BITS   = 5'd2;

  // ----------
  // Types
  // ----------
  typedef enum logic [1:0] {ST_IDLE, ST_TUNE, ST_TX, ST_RX} rfc_state_type;

  typedef struct packed {
    logic [RATE_DIV_W-1:0] div_cnt;
    logic [RATE_ACC_W-1:0] acc;
    logic                  tick;
  } rfc_rate_type;

  typedef struct packed {
    logic [7:0]              txdr_high;
    logic [7:0]              txdr_low;
    logic [7:0]              mod_ctl2;
    logic [7:0]              dev_low;
    logic [7:0]              ofs_low;
    logic [1:0]              ofs_high;
    logic [7:0]              hop_chan;
    logic [7:0]              hop_step;
    logic [7:0]              applied_chan;
    logic [7:0]              applied_step;
    rfc_state_type           state;
    rfc_state_type           resume;
    logic [TUNE_CNT_W-1:0]   tune_cnt;
    logic                    hop_pending;
    logic signed [7:0]       afc_corr;
    logic                    afc_frozen;
    logic [4:0]              afc_bits;
    logic signed [FREQ_W-1:0] freq_delta;
    logic [10:0]             deviation;
    logic [7:0]              rdata;
  } rfc_regs_type;

endpackage

//--- rtl/rfc_rate_gen.sv
// Transmit bit-rate generator: 1 MHz phase accumulator with prescale
module rfc_rate_gen
  import rfc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        enable_i,
  input  wire logic [15:0] rate_word_i,
  input  wire logic        prescale_i,
  output logic             bit_tick_o
);

  rfc_rate_type q;
  rfc_rate_type d;

  logic [RATE_ACC_W:0] sum;

  // ----------
  // Accumulate the rate word once per microsecond
  // ----------
  always_comb begin
    d    = q;
    sum  = {1'b0, q.acc} + {6'h00, rate_word_i};
    d.tick = 1'b0;
    if (!enable_i) begin
      d.div_cnt = '0;
      d.acc     = '0;
    end else if (q.div_cnt == RATE_DIV_W'(RATE_DIV - 1)) begin
      d.div_cnt = '0;
      // Carry out of bit 16 or bit 21 divides by 2^(16 + 5*prescale)
      if (prescale_i) begin
        d.tick = sum[RATE_ACC_W];
        d.acc  = sum[RATE_ACC_W-1:0];
      end else begin
        d.tick = sum[RATE_SHIFT_BASE];
        d.acc  = {5'h00, sum[RATE_SHIFT_BASE-1:0]};
      end
    end else begin
      d.div_cnt = q.div_cnt + RATE_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_tick_o = q.tick;

endmodule

//--- rtl/rfc_top.sv
// Frequency control: hopping, deviation, offset/AFC correction, tune sequencing
module rfc_top
  import rfc_pkg::*;
#(
  parameter int TUNE_CNT = TUNE_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [6:0]               reg_addr_i,
  input  wire logic [7:0]               reg_wdata_i,
  output logic      [7:0]               reg_rdata_o,
  input  wire logic                     tx_on_i,
  input  wire logic                     rx_on_i,
  input  wire logic                     fifo_mode_i,
  input  wire logic                     tx_packet_active_i,
  input  wire logic                     band_half_select_i,
  input  wire logic                     tx_rate_prescale_i,
  input  wire logic                     afc_enable_i,
  input  wire logic [2:0]               afc_gain_shift_i,
  input  wire logic [2:0]               afc_cycle_length_i,
  input  wire logic [7:0]               pull_in_limit_i,
  input  wire logic signed [7:0]        afc_error_i,
  input  wire logic                     rx_bit_tick_i,
  input  wire logic                     preamble_detect_i,
  input  wire logic                     packet_end_i,
  input  wire logic                     multi_packet_i,
  output rfc_state_type                 state_o,
  output logic signed [FREQ_W-1:0]      freq_delta_o,
  output logic      [10:0]              deviation_o,
  output logic signed [7:0]             afc_correction_value_o,
  output logic                          tx_bit_tick_o
);

  localparam logic [TUNE_CNT_W-1:0] TUNE_LAST = TUNE_CNT_W'(TUNE_CNT - 1);

  rfc_regs_type q;
  rfc_regs_type d;

  logic                     hop_write;
  logic                     go_tune;
  logic [4:0]               cycle_bits;
  logic signed [9:0]        lim;
  logic signed [9:0]        afc_sum;
  logic signed [9:0]        corr_word;
  logic signed [FREQ_W-1:0] hop_term;
  logic signed [FREQ_W-1:0] corr_term;
  logic [15:0]              hop_prod;
  logic                     rx_tuning;

  // ----------
  // Next-state logic
  // ----------
  always_comb begin
    d          = q;
    go_tune    = 1'b0;
    hop_write  = 1'b0;
    cycle_bits = AFC_MEAS_BITS + {1'b0, afc_cycle_length_i, 1'b0};
    lim        = 10'sd0;
    afc_sum    = 10'sd0;

    // Register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_TXDR_HIGH: d.txdr_high = reg_wdata_i;
        ADDR_TXDR_LOW:  d.txdr_low  = reg_wdata_i;
        ADDR_MOD_CTL2:  d.mod_ctl2  = reg_wdata_i;
        ADDR_DEV_LOW:   d.dev_low   = reg_wdata_i;
        ADDR_OFS_LOW:   d.ofs_low   = reg_wdata_i;
        ADDR_OFS_HIGH:  d.ofs_high  = reg_wdata_i[1:0];
        ADDR_HOP_CHAN: begin
          d.hop_chan = reg_wdata_i;
          hop_write  = 1'b1;
        end
        ADDR_HOP_STEP: begin
          d.hop_step = reg_wdata_i;
          hop_write  = 1'b1;
        end
        default: ;
      endcase
    end

    // Operating state sequencing
    unique case (q.state)
      ST_IDLE: begin
        if (tx_on_i || rx_on_i) begin
          go_tune  = 1'b1;
          d.resume = tx_on_i ? ST_TX : ST_RX;
        end
      end
      ST_TUNE: begin
        if (!tx_on_i && !rx_on_i) begin
          d.state = ST_IDLE;
        end else if (q.tune_cnt == TUNE_LAST) begin
          d.state = q.resume;
        end else begin
          d.tune_cnt = q.tune_cnt + TUNE_CNT_W'(1);
        end
      end
      ST_TX: begin
        if (!tx_on_i) begin
          d.state       = ST_IDLE;
          d.hop_pending = 1'b0;
        end else if (hop_write || q.hop_pending) begin
          // Packet in flight stays on the old channel
          if (fifo_mode_i && tx_packet_active_i) begin
            d.hop_pending = 1'b1;
          end else begin
            go_tune       = 1'b1;
            d.resume      = ST_TX;
            d.hop_pending = 1'b0;
          end
        end
      end
      ST_RX: begin
        if (!rx_on_i) begin
          d.state = ST_IDLE;
        end else if (hop_write) begin
          go_tune  = 1'b1;
          d.resume = ST_RX;
        end
      end
    endcase

    // Hop setting reaches the synthesizer only when idle or retuning
    if (go_tune || q.state == ST_IDLE || q.state == ST_TUNE) begin
      d.applied_chan = d.hop_chan;
      d.applied_step = d.hop_step;
    end
    if (go_tune) begin
      d.state    = ST_TUNE;
      d.tune_cnt = '0;
    end

    // ----------
    // AFC loop
    // ----------
    if (q.state != ST_RX || !afc_enable_i) begin
      d.afc_corr   = 8'sd0;
      d.afc_frozen = 1'b0;
      d.afc_bits   = '0;
    end else if (packet_end_i) begin
      d.afc_frozen = preamble_detect_i;
      d.afc_bits   = '0;
      if (multi_packet_i) begin
        d.afc_corr = 8'sd0;
      end
    end else if (preamble_detect_i || q.afc_frozen) begin
      d.afc_frozen = 1'b1;
    end else if (rx_bit_tick_i && afc_cycle_length_i != 3'h0) begin
      // Two bits measuring, the rest settling
      if (q.afc_bits == cycle_bits - 5'd1) begin
        d.afc_bits = '0;
      end else begin
        d.afc_bits = q.afc_bits + 5'd1;
      end
      if (q.afc_bits == AFC_MEAS_BITS - 5'd1) begin
        afc_sum = 10'(q.afc_corr) + 10'(afc_error_i >>> afc_gain_shift_i);
        // Large limits saturate at the 8-bit correction range
        lim = 10'(AFC_MAX);
        if (pull_in_limit_i <= 8'(AFC_MAX >>> LIMIT_SHIFT)) begin
          lim = $signed(10'({2'b00, pull_in_limit_i} << LIMIT_SHIFT));
        end
        if (afc_sum > lim) begin
          afc_sum = lim;
        end else if (afc_sum < -lim) begin
          afc_sum = -lim;
        end
        d.afc_corr = afc_sum[7:0];
      end
    end

    // ----------
    // Synthesizer word, in 156.25 Hz carrier steps from nominal
    // ----------
    hop_prod  = q.applied_step * q.applied_chan;
    hop_term  = $signed({2'b00, hop_prod, {HOP_UNIT_SHIFT{1'b0}}});
    // Transmit keeps the manual offset; AFC owns it only in receive
    if (q.state == ST_RX && afc_enable_i) begin
      corr_word = 10'(q.afc_corr);
    end else begin
      corr_word = $signed({q.ofs_high, q.ofs_low});
    end
    corr_term = FREQ_W'(corr_word);
    if (band_half_select_i) begin
      corr_term = corr_term <<< 1;
    end
    rx_tuning    = q.state == ST_RX || (q.state == ST_TUNE && q.resume == ST_RX);
    d.freq_delta = hop_term + corr_term;
    if (rx_tuning) begin
      d.freq_delta = hop_term + corr_term - IF_SHIFT_WORD;
    end
    // Deviation step is fixed, independent of band half
    d.deviation = 11'({q.mod_ctl2[DEV_TOP_BIT], q.dev_low}) << DEV_UNIT_SHIFT;

    // ----------
    // Read data, one cycle after the address
    // ----------
    unique case (reg_addr_i)
      ADDR_AFC_CORR:  d.rdata = q.afc_corr;
      ADDR_TXDR_HIGH: d.rdata = q.txdr_high;
      ADDR_TXDR_LOW:  d.rdata = q.txdr_low;
      ADDR_MOD_CTL2:  d.rdata = q.mod_ctl2;
      ADDR_DEV_LOW:   d.rdata = q.dev_low;
      ADDR_OFS_LOW:   d.rdata = q.ofs_low;
      ADDR_OFS_HIGH:  d.rdata = {6'h00, q.ofs_high};
      ADDR_HOP_CHAN:  d.rdata = q.hop_chan;
      ADDR_HOP_STEP:  d.rdata = q.hop_step;
      default:        d.rdata = 8'h00;
    endcase
  end

  // ----------
  // State register
  // ----------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q              <= '0;
      q.txdr_high    <= RST_TXDR_HIGH;
      q.txdr_low     <= RST_TXDR_LOW;
      q.mod_ctl2     <= RST_MOD_CTL2;
      q.dev_low      <= RST_DEV_LOW;
      q.ofs_low      <= RST_OFS_LOW;
      q.ofs_high     <= RST_OFS_HIGH;
      q.hop_chan     <= RST_HOP_CHAN;
      q.hop_step     <= RST_HOP_STEP;
      q.applied_chan <= RST_HOP_CHAN;
      q.applied_step <= RST_HOP_STEP;
      q.state        <= ST_IDLE;
      q.resume       <= ST_IDLE;
      q.deviation    <= 11'({RST_MOD_CTL2[DEV_TOP_BIT], RST_DEV_LOW}) << DEV_UNIT_SHIFT;
    end else begin
      q <= d;
    end
  end

  // ----------
  // Transmit bit clock; idle outside transmit so receive never sees it
  // ----------
  rfc_rate_gen u_rate (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .enable_i   (q.state == ST_TX),
    .rate_word_i({q.txdr_high, q.txdr_low}),
    .prescale_i (tx_rate_prescale_i),
    .bit_tick_o (tx_bit_tick_o)
  );

  assign reg_rdata_o            = q.rdata;
  assign state_o                = q.state;
  assign freq_delta_o           = q.freq_delta;
  assign deviation_o            = q.deviation;
  assign afc_correction_value_o = q.afc_corr;

endmodule
